// ===== logic/ccs_pkg.sv
/*
  constants for the common command and status block: register offsets,
  field positions, defaults and codes.
  assumes byte addresses on an 8-bit register port with 32-bit data.
*/
`default_nettype none
package ccs_pkg;
  // register offsets
  localparam logic [7:0] A_CLS   = 8'h00; // write: clear status
  localparam logic [7:0] A_ESE   = 8'h04; // event enable mask
  localparam logic [7:0] A_ESR   = 8'h08; // event status, read clears
  localparam logic [7:0] A_SRE   = 8'h0c; // service request enable
  localparam logic [7:0] A_STB   = 8'h10; // status byte with mss
  localparam logic [7:0] A_PSC   = 8'h14; // power-on status clear flag
  localparam logic [7:0] A_OPC   = 8'h18; // write arms, read = done
  localparam logic [7:0] A_RST   = 8'h1c; // write: reset command
  localparam logic [7:0] A_IDN0  = 8'h20; // maker code
  localparam logic [7:0] A_IDN1  = 8'h24; // model code
  localparam logic [7:0] A_IDN2  = 8'h28; // serial number
  localparam logic [7:0] A_IDN3  = 8'h2c; // {main fw, option fw}
  localparam logic [7:0] A_OPT   = 8'h30; // installed board code
  localparam logic [7:0] A_ERR   = 8'h34; // error queue pop
  localparam logic [7:0] A_SPOLL = 8'h38; // serial poll, clears rqs
  localparam logic [7:0] A_OUT   = 8'h40; // output controls
  localparam logic [7:0] A_CHAN  = 8'h44; // channel selects
  localparam logic [7:0] A_TSRC  = 8'h48; // trigger sources
  localparam logic [7:0] A_TVOLT = 8'h4c; // triggered voltage target
  localparam logic [7:0] A_TCURR = 8'h50; // triggered current target
  localparam logic [7:0] A_DON   = 8'h54; // output on delay
  localparam logic [7:0] A_DOFF  = 8'h58; // output off delay
  localparam logic [7:0] A_LOCK  = 8'h5c; // panel lock
  // status byte and event status bit positions
  localparam int SB_EAV  = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV  = 4;
  localparam int SB_ESB  = 5;
  localparam int SB_RQS  = 6;
  localparam int ES_OPC  = 0;
  localparam int ES_EXE  = 4;
  // limits, codes and defaults
  localparam logic [31:0] MASK_MAX   = 32'h0000_00ff;
  localparam logic [31:0] PSC_MAX    = 32'h0000_0001;
  localparam logic [15:0] ERR_RANGE  = 16'hff22; // -222 two's complement
  localparam logic [15:0] CURRENT_SETPOINT_MAX   = 16'hffff; // full-scale current
  localparam logic [15:0] VOLTAGE_SETPOINT_DFLT  = 16'h0000;
  localparam logic [15:0] DELAY_DFLT = 16'h0000;
  localparam logic [1:0]  CH_ONE     = 2'h0;
  localparam logic        SRC_BUS    = 1'b0;
  localparam logic [1:0]  TRK_OFF    = 2'h0;
  localparam logic [3:0]  COUP_NONE  = 4'h0;
  localparam logic        PSC_DFLT   = 1'b0;
  localparam logic [1:0]  BOARD_SER  = 2'h1; // serial-port board code
  localparam int          ERR_DEPTH  = 4;
  // identity values: arbitrary, not any real part
  localparam logic [31:0] MAKER_ID   = 32'h0000_0a5a;
  localparam logic [31:0] MODEL_ID   = 32'h0000_1234;
  localparam logic [31:0] SERIAL_NUM = 32'h0000_0001;
  localparam logic [15:0] FW_MAIN    = 16'h0100; // 1.00 in bcd
  localparam logic [15:0] FW_OPTION  = 16'h0101; // 1.01 in bcd
  localparam logic [15:0] FW_NONE    = 16'h0000; // 0.00
endpackage : ccs_pkg
`default_nettype wire

// ===== logic/status_if.sv
/*
  signals between the command decoder and the status core.
  assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface status_if;
  logic        cls;      // clear status pulse
  logic        esr_rd;   // event status read pulse
  logic        err_pop;  // error queue read pulse
  logic        log_err;  // push out-of-range code
  logic [7:0]  events;   // event bits to set this cycle
  logic [7:0]  esr;      // event status register
  logic [15:0] err_head; // oldest code, zero when empty
  logic        err_any;  // queue not empty
  modport core (input cls, esr_rd, err_pop, log_err, events,
                output esr, err_head, err_any);
  modport ctrl (output cls, esr_rd, err_pop, log_err, events,
                input esr, err_head, err_any);
endinterface : status_if
`default_nettype wire

// ===== logic/status_core.sv
/*
  event status register and error queue.
  assumes pulses from the decoder last one cycle each.
*/
`timescale 1ns/1ps
`default_nettype none
module status_core
  import ccs_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  status_if.core    st
);
  logic [15:0] queue [ERR_DEPTH]; // error codes, oldest at rd_ptr
  logic [1:0]  rd_ptr;            // oldest entry
  logic [1:0]  wr_ptr;            // next free entry
  logic [2:0]  count;             // entries held
  logic        push;              // accepted push
  logic        pop;               // accepted pop

  // a full queue drops the new code so the oldest cause survives
  assign push = st.log_err && (count != 3'(ERR_DEPTH));
  assign pop  = st.err_pop && (count != 3'h0);

  // event bits arriving with a clear or a read still land: set wins
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st.esr <= 8'h00;
    end else begin
      st.esr <= ((st.esr_rd || st.cls) ? 8'h00 : st.esr) | st.events;
    end
  end

  // queue pointers; clear empties the queue
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || st.cls) begin
      rd_ptr <= 2'h0;
      wr_ptr <= 2'h0;
      count  <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      count <= count + 3'(push) - 3'(pop);
    end
  end

  // storage needs no reset; only counted entries are read
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      queue[wr_ptr] <= ERR_RANGE;
    end
  end

  assign st.err_any  = (count != 3'h0);
  assign st.err_head = st.err_any ? queue[rd_ptr] : 16'h0000;
endmodule : status_core
`default_nettype wire

// ===== logic/common_command_status_logic.sv
/*
  common command handler: status byte, event status and enable masks,
  service request, identify, option, power-on status, reset defaults.
  assumes a register port with one-cycle strobes, read data one cycle
  after the read strobe, and a synchronous active-high factory reset.
  limitation: the error queue keeps only the first four codes of a burst
  of bad writes; later codes are dropped so the oldest cause survives.
*/
`timescale 1ns/1ps
`default_nettype none
module common_command_status_logic
  import ccs_pkg::*;
(
  input  wire logic        i_clk_sys,      // 20 MHz system clock
  input  wire logic        i_srst,         // factory reset
  input  wire logic [7:0]  i_addr,         // register byte address
  input  wire logic [31:0] i_wdata,        // write data
  input  wire logic        i_wr,           // write strobe
  input  wire logic        i_rd,           // read strobe
  input  wire logic        i_busy,         // commands still pending
  input  wire logic        i_power_on,     // power-up event pulse
  input  wire logic        i_ques_summary, // questionable summary
  input  wire logic        i_mav,          // message available
  input  wire logic [7:0]  i_dev_events,   // other event status bits
  input  wire logic [1:0]  i_board,        // installed board code
  output logic      [31:0] o_rdata,        // read data
  output logic             o_srq,          // service request
  output logic             o_output_enable,
  output logic             o_abort_meas,   // measurement abort pulse
  output logic             o_panel_lock
);
  status_if st ();

  status_core u_core (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .st        (st)
  );

  // range check shared by the mask and flag writes
  function automatic logic in_range(input logic [31:0] v,
                                    input logic [31:0] lim);
    in_range = (v <= lim);
  endfunction : in_range

  // write and read decode
  function automatic logic hit(input logic s, input logic [7:0] a,
                               input logic [7:0] r);
    hit = s && (a == r);
  endfunction : hit

  // status masks and flags
  logic [7:0]  ese;            // event enable mask
  logic [7:0]  sre;            // service request enable mask
  logic        psc;            // power-on status clear flag
  logic        opc_armed;      // operation complete pending
  logic        opc_fire;       // operation complete event
  logic        rqs;            // request service flag
  logic        summary_q;      // summary one cycle ago
  logic        summary;        // any enabled status bit
  logic [7:0]  stb;            // status byte without bit 6
  logic        rst_cmd;        // reset command strobe
  logic        bad_param;      // out-of-range write
  // settings that reset loads with defaults; power-up loads only some of them
  logic        tracking_on;    // tracking active, read only
  logic [1:0]  tracking_mode;
  logic        output_delay_enable;
  logic        powerup_output_state;
  logic [1:0]  command_channel_select;
  logic [1:0]  display_channel_select;
  logic [3:0]  channel_coupling;
  logic        seq_one_trigger_source;
  logic        seq_two_trigger_source;
  logic [15:0] triggered_voltage_target;
  logic [15:0] triggered_current_target;
  logic [15:0] output_on_delay;
  logic [15:0] output_off_delay;
  // decoded mask and flag writes
  logic        w_ese;          // event enable write
  logic        w_sre;          // service enable write
  logic        w_psc;          // power-on flag write

  // write decode and the read-only tracking bit
  assign tracking_on = (tracking_mode != TRK_OFF);
  assign w_ese   = hit(i_wr, i_addr, A_ESE);
  assign w_sre   = hit(i_wr, i_addr, A_SRE);
  assign w_psc   = hit(i_wr, i_addr, A_PSC);
  assign rst_cmd = hit(i_wr, i_addr, A_RST);

  // out-of-range parameters are not stored, only logged
  assign bad_param = (w_ese && !in_range(i_wdata, MASK_MAX))
                  || (w_sre && !in_range(i_wdata, MASK_MAX))
                  || (w_psc && !in_range(i_wdata, PSC_MAX));

  // strobes into the status core
  assign st.cls     = hit(i_wr, i_addr, A_CLS);
  assign st.esr_rd  = hit(i_rd, i_addr, A_ESR);
  assign st.err_pop = hit(i_rd, i_addr, A_ERR);
  assign st.log_err = bad_param;

  // the range error is an execution error in the event status
  always_comb begin
    st.events         = i_dev_events;
    st.events[ES_OPC] = i_dev_events[ES_OPC] | opc_fire;
    st.events[ES_EXE] = i_dev_events[ES_EXE] | bad_param;
  end

  // status byte; bit 6 is filled per query type
  always_comb begin
    stb           = 8'h00;
    stb[SB_EAV]   = st.err_any;
    stb[SB_QUES]  = i_ques_summary;
    stb[SB_MAV]   = i_mav;
    stb[SB_ESB]   = |(st.esr & ese);
  end

  // bit 6 is masked out so the flag cannot feed itself
  assign summary = |(stb & sre & ~(8'h01 << SB_RQS));

  // masks and power-on flag; power-up clears masks when flag is 1
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ese <= 8'h00;
      sre <= 8'h00;
      psc <= PSC_DFLT;
    end else if (i_power_on && psc) begin
      ese <= 8'h00;
      sre <= 8'h00;
    end else begin
      if (w_ese && in_range(i_wdata, MASK_MAX)) begin
        ese <= i_wdata[7:0];
      end
      if (w_sre && in_range(i_wdata, MASK_MAX)) begin
        sre <= i_wdata[7:0];
      end
      if (w_psc && in_range(i_wdata, PSC_MAX)) begin
        psc <= i_wdata[0];
      end
    end
  end

  // operation complete waits for pending commands to drain
  // an arm with nothing pending fires on the very next edge
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || st.cls) begin
      opc_armed <= 1'b0;
      opc_fire  <= 1'b0;
    end else begin
      opc_fire  <= opc_armed && !i_busy;
      if (hit(i_wr, i_addr, A_OPC)) begin
        opc_armed <= 1'b1;
      end else if (!i_busy) begin
        opc_armed <= 1'b0;
      end
    end
  end

  // request service: set on a rising summary, cleared by poll or clear
  // a summary that stays high raises only one request
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rqs       <= 1'b0;
      summary_q <= 1'b0;
    end else begin
      summary_q <= summary;
      if (summary && !summary_q) begin
        rqs <= 1'b1;
      end else if (st.cls || hit(i_rd, i_addr, A_SPOLL)) begin
        rqs <= 1'b0;
      end
    end
  end

  // service request line follows enabled status
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_srq <= 1'b0;
    end else begin
      o_srq <= summary;
    end
  end

  // output state: off on factory and command reset
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || rst_cmd) begin
      o_output_enable <= 1'b0;
    end else if (i_power_on) begin
      o_output_enable <= powerup_output_state;
    end else if (hit(i_wr, i_addr, A_OUT)) begin
      o_output_enable <= i_wdata[0];
    end
  end

  // output options; delay enable survives a power cycle
  // tracking restarts off so a stale reference is never reused
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || rst_cmd) begin
      output_delay_enable  <= 1'b0;
      powerup_output_state <= 1'b0;
      tracking_mode        <= TRK_OFF;
    end else if (i_power_on) begin
      tracking_mode        <= TRK_OFF;
    end else if (hit(i_wr, i_addr, A_OUT)) begin
      output_delay_enable  <= i_wdata[1];
      powerup_output_state <= i_wdata[2];
      tracking_mode        <= i_wdata[5:4];
    end
  end

  // channel selects; display channel is kept across power-up
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || rst_cmd) begin
      command_channel_select <= CH_ONE;
      display_channel_select <= CH_ONE;
      channel_coupling       <= COUP_NONE;
    end else if (i_power_on) begin
      command_channel_select <= CH_ONE;
      channel_coupling       <= COUP_NONE;
    end else if (hit(i_wr, i_addr, A_CHAN)) begin
      command_channel_select <= i_wdata[1:0];
      display_channel_select <= i_wdata[3:2];
      channel_coupling       <= i_wdata[7:4];
    end
  end

  // trigger sources and targets: defaults at every start
  // a reset command and a power-up load the same values here
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || rst_cmd || i_power_on) begin
      seq_one_trigger_source   <= SRC_BUS;
      seq_two_trigger_source   <= SRC_BUS;
      triggered_voltage_target <= VOLTAGE_SETPOINT_DFLT;
      triggered_current_target <= CURRENT_SETPOINT_MAX;
    end else begin
      if (hit(i_wr, i_addr, A_TSRC)) begin
        seq_one_trigger_source <= i_wdata[0];
        seq_two_trigger_source <= i_wdata[1];
      end
      if (hit(i_wr, i_addr, A_TVOLT)) begin
        triggered_voltage_target <= i_wdata[15:0];
      end
      if (hit(i_wr, i_addr, A_TCURR)) begin
        triggered_current_target <= i_wdata[15:0];
      end
    end
  end

  // delays are non-volatile: power-up leaves them alone
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || rst_cmd) begin
      output_on_delay  <= DELAY_DFLT;
      output_off_delay <= DELAY_DFLT;
    end else begin
      if (hit(i_wr, i_addr, A_DON)) begin
        output_on_delay <= i_wdata[15:0];
      end
      if (hit(i_wr, i_addr, A_DOFF)) begin
        output_off_delay <= i_wdata[15:0];
      end
    end
  end

  // panel lock: of the resets, only the factory reset clears it
  // a remote reset must not unlock a panel locked on purpose
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_panel_lock <= 1'b0;
    end else if (hit(i_wr, i_addr, A_LOCK)) begin
      o_panel_lock <= i_wdata[0];
    end
  end

  // measurement abort pulse on the reset command
  // one pulse per command; the measurement side stops on it
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_abort_meas <= 1'b0;
    end else begin
      o_abort_meas <= rst_cmd;
    end
  end

  // read data, valid in the cycle after the strobe only
  // a cycle without a strobe zeroes the word so nothing stale lingers
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      unique case (i_addr)
        A_ESE:   o_rdata <= {24'h00_0000, ese};
        A_ESR:   o_rdata <= {24'h00_0000, st.esr};
        A_SRE:   o_rdata <= {24'h00_0000, sre};
        A_STB:   o_rdata <= {24'h00_0000,
                             stb | ({7'h00, summary} << SB_RQS)};
        A_SPOLL: o_rdata <= {24'h00_0000,
                             stb | ({7'h00, rqs} << SB_RQS)};
        A_PSC:   o_rdata <= {31'h0000_0000, psc};
        A_OPC:   o_rdata <= {31'h0000_0000,
                             !i_busy && !opc_armed};
        A_IDN0:  o_rdata <= MAKER_ID;
        A_IDN1:  o_rdata <= MODEL_ID;
        A_IDN2:  o_rdata <= SERIAL_NUM;
        A_IDN3:  o_rdata <= {FW_MAIN, (i_board == BOARD_SER) ?
                             FW_NONE : FW_OPTION};
        A_OPT:   o_rdata <= {30'h0000_0000, i_board};
        A_ERR:   o_rdata <= {16'h0000, st.err_head};
        A_OUT:   o_rdata <= {26'h000_0000, tracking_mode,
                             tracking_on, powerup_output_state,
                             output_delay_enable, o_output_enable};
        A_CHAN:  o_rdata <= {24'h00_0000, channel_coupling,
                             display_channel_select,
                             command_channel_select};
        A_TSRC:  o_rdata <= {30'h0000_0000, seq_two_trigger_source,
                             seq_one_trigger_source};
        A_TVOLT: o_rdata <= {16'h0000, triggered_voltage_target};
        A_TCURR: o_rdata <= {16'h0000, triggered_current_target};
        A_DON:   o_rdata <= {16'h0000, output_on_delay};
        A_DOFF:  o_rdata <= {16'h0000, output_off_delay};
        A_LOCK:  o_rdata <= {31'h0000_0000, o_panel_lock};
        default: o_rdata <= 32'h0000_0000;                     // unmapped
      endcase
    end
  end
endmodule : common_command_status_logic
`default_nettype wire

// ===== bench/ccs_assertions.sv
/* port checker for the common command block.
   assumes one clock and the bind below the module. */
`timescale 1ns/1ps
`default_nettype none
module ccs_assertions
  import ccs_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [1:0]  i_board,
  input wire logic [31:0] o_rdata,
  input wire logic        o_srq,
  input wire logic        o_output_enable,
  input wire logic        o_abort_meas,
  input wire logic        o_panel_lock
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // reset command write taken at this edge
  wire w_rst = i_wr && i_addr == A_RST;
  property p_abort; w_rst |=> o_abort_meas; endproperty
  a_abort: assert property (p_abort) else $error("abort missing");
  property p_abort_src; o_abort_meas |-> $past(w_rst); endproperty
  a_abort_src: assert property (p_abort_src) else $error("stray abort");
  property p_out_rst; w_rst |=> !o_output_enable; endproperty
  a_out_rst: assert property (p_out_rst) else $error("output on");
  property p_lock_rst; w_rst |=> $stable(o_panel_lock); endproperty
  a_lock_rst: assert property (p_lock_rst) else $error("lock moved");
  property p_idn; i_rd && i_addr == A_IDN0 |=> o_rdata == MAKER_ID;
  endproperty
  a_idn: assert property (p_idn) else $error("maker code wrong");
  // option firmware reads zero behind the serial board
  property p_fw;
    i_rd && i_addr == A_IDN3 && i_board == BOARD_SER
      |=> o_rdata[15:0] == FW_NONE;
  endproperty
  a_fw: assert property (p_fw) else $error("option fw wrong");
  property p_opt; i_rd && i_addr == A_OPT |=> o_rdata[1:0] == $past(i_board);
  endproperty
  a_opt: assert property (p_opt) else $error("board code wrong");
  // a legal mask written, then read back two cycles later
  property p_ese;
    i_wr && i_addr == A_ESE && i_wdata <= MASK_MAX ##2 i_rd && i_addr == A_ESE
      |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_ese: assert property (p_ese) else $error("mask lost");
  // srq is one cycle behind the mask, so allow one extra edge
  property p_sre0; i_wr && i_addr == A_SRE && i_wdata == 0 |=> ##1 !o_srq;
  endproperty
  a_sre0: assert property (p_sre0) else $error("srq after zero");
  c_rst: cover property (w_rst);
  c_srq: cover property (o_srq);
  c_esr: cover property (i_rd && i_addr == A_ESR);
endmodule : ccs_assertions
bind common_command_status_logic ccs_assertions ccs_assertions_i (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_board(i_board),
  .o_rdata(o_rdata), .o_srq(o_srq), .o_output_enable(o_output_enable),
  .o_abort_meas(o_abort_meas), .o_panel_lock(o_panel_lock));
`default_nettype wire

// ===== bench/host_model.sv
/* host controller: one register access at a time.
   assumes the bench clock; strobes last one cycle. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        i_clk_sys,
  input  wire logic [31:0] i_rdata,
  output var  logic [7:0]  o_addr,
  output var  logic [31:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd
);
  // bus idle from time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // write: strobe held for exactly one edge; address and data stay until the next access
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
  endtask : wr
  // read: data stands only in the cycle after the strobe; taken
  // mid-cycle, then return on an edge so callers drive there
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    @(negedge i_clk_sys);
    d = i_rdata;
    @(posedge i_clk_sys);
  endtask : rd
endmodule : host_model
`default_nettype wire

// ===== bench/common_command_status_logic_tb.sv
/* bench: host model, status reference model, directed and random checks.
   assumes the package, interface and design files compile first. */
`timescale 1ns/1ps
`default_nettype none
module common_command_status_logic_tb;
  import ccs_pkg::*;
  logic        i_clk_sys, i_srst, i_busy, i_power_on, i_ques_summary, i_mav;
  logic        i_wr, i_rd, o_srq, o_output_enable, o_abort_meas, o_panel_lock;
  logic [7:0]  i_addr, i_dev_events;
  logic [31:0] i_wdata, o_rdata;
  logic [1:0]  i_board;
  int          failures, tests_run, seed, esr, v, lk;
  int          errq[$]; // reference error queue
  logic [7:0]  dflt_a[9] = '{A_OUT, A_CHAN, A_TSRC, A_TVOLT, A_TCURR,
                             A_DON, A_DOFF, A_LOCK, 8'h3c};
  common_command_status_logic common_command_status_logic_i (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_busy(i_busy),
    .i_power_on(i_power_on), .i_ques_summary(i_ques_summary),
    .i_mav(i_mav), .i_dev_events(i_dev_events), .i_board(i_board),
    .o_rdata(o_rdata), .o_srq(o_srq), .o_output_enable(o_output_enable),
    .o_abort_meas(o_abort_meas), .o_panel_lock(o_panel_lock));
  host_model host_model_i (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // a hang counts as a mismatch; the run needs far fewer cycles
  initial begin
    #2000000;
    failures++;
    finish_test();
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_i.wr(a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host_model_i.rd(a, d);
    check(d, exp);
  endtask : rchk
  // out-of-range write: model logs the code unless the queue is full
  task automatic bad(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    esr |= 1 << ES_EXE;
    if (errq.size() < ERR_DEPTH) errq.push_back(ERR_RANGE);
  endtask : bad
  task automatic pulse(input logic [7:0] e, input logic p);
    @(posedge i_clk_sys);
    i_dev_events <= e;
    i_power_on <= p;
    @(posedge i_clk_sys);
    i_dev_events <= 8'h00;
    i_power_on <= 1'b0;
  endtask : pulse
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc
  // setting defaults; the lock alone survives a reset command
  function automatic logic [31:0] dflt(input logic [7:0] a);
    if (a == A_TCURR) return {16'h0000, CURRENT_SETPOINT_MAX};
    return (a == A_LOCK) ? lk : 32'h0000_0000;
  endfunction : dflt
  initial begin
    i_srst = 1'b1;
    i_busy = 1'b0;
    i_power_on = 1'b0;
    i_ques_summary = 1'b0;
    i_mav = 1'b0;
    i_dev_events = 8'h00;
    i_board = 2'h0;
    seed = 81473;
    repeat (5) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    foreach (dflt_a[k]) rchk(dflt_a[k], dflt(dflt_a[k]));
    rchk(A_IDN0, MAKER_ID);
    rchk(A_IDN2, SERIAL_NUM);
    for (int b = 0; b < 4; b++) begin
      i_board <= b[1:0];
      rchk(A_OPT, 32'(b));
      rchk(A_IDN3, {FW_MAIN, b == BOARD_SER ? FW_NONE : FW_OPTION});
    end
    for (int k = 0; k < 4; k++) begin
      v = (k == 3) ? 255 : $random(seed) & 255;
      wr(A_ESE, v);
      rchk(A_ESE, v);
      wr(A_SRE, v ^ 255);
      rchk(A_SRE, v ^ 255);
    end
    bad(A_ESE, 256);
    bad(A_SRE, 300);
    bad(A_PSC, 2);
    rchk(A_ESE, 255);
    rchk(A_PSC, 0);
    pulse(8'h80, 1'b0);
    rchk(A_ESR, esr | 32'h80);
    esr = 0;
    rchk(A_ESR, esr);
    while (errq.size() > 0) rchk(A_ERR, errq.pop_front());
    wr(A_SRE, 8);
    i_ques_summary <= 1'b1;
    i_mav <= 1'b1;
    cyc(3);
    check(o_srq, 1);
    v = 1 << SB_QUES | 1 << SB_MAV;
    rchk(A_STB, v | 1 << SB_RQS);
    rchk(A_SPOLL, v | 1 << SB_RQS);
    rchk(A_SPOLL, v);
    wr(A_SRE, 0);
    cyc(2);
    check(o_srq, 0);
    pulse(8'h20, 1'b0);
    bad(A_PSC, 5);
    wr(A_CLS, 0);
    esr = 0;
    errq.delete();
    rchk(A_ESR, esr);
    rchk(A_ERR, 0);
    i_busy <= 1'b1;
    wr(A_OPC, 0);
    cyc(4);
    rchk(A_ESR, 0);
    i_busy <= 1'b0;
    cyc(4);
    rchk(A_ESR, 1 << ES_OPC);
    rchk(A_OPC, 1);
    foreach (dflt_a[k]) wr(dflt_a[k], 5);
    check(o_output_enable, 1);
    wr(A_RST, 0);
    cyc(0);
    check(o_abort_meas, 1);
    lk = 1;
    foreach (dflt_a[k]) rchk(dflt_a[k], dflt(dflt_a[k]));
    check(o_output_enable, 0);
    check(o_panel_lock, 1);
    wr(A_PSC, 1);
    wr(A_SRE, 5);
    wr(A_OUT, 32'h0000_0034);
    wr(A_DON, 9);
    wr(A_CHAN, 9);
    pulse(8'h00, 1'b1);
    rchk(A_ESE, 0);
    rchk(A_SRE, 0);
    check(o_output_enable, 1);
    rchk(A_OUT, 5);
    rchk(A_DON, 9);
    rchk(A_CHAN, 8);
    wr(A_PSC, 0);
    wr(A_ESE, 5);
    pulse(8'h00, 1'b1);
    rchk(A_ESE, 5);
    finish_test();
  end
endmodule : common_command_status_logic_tb
`default_nettype wire
